// >>> core/sma_core.sv
`timescale 1ns/1ps
module sma_core
    import sma_pkg::*;
#(
    parameter int PROG_N  = PROG_CYCLES,
    parameter int ERASE_N = ERASE_CYCLES
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // address select straps
    input  wire logic       addrSelectHiPin,
    input  wire logic       addrSelectLoPin,
    // two-wire bus
    input  wire smaPinIn_s  pinIn,
    output smaPinOut_s      pinOut
);
    function automatic logic isRamCmd(input logic [7:0] c);
        return c <= RAM_TOP;
    endfunction

    function automatic logic isEeCmd(input logic [7:0] c);
        return (c >= CMD_EE_LO) && (c <= CMD_EE_HI);
    endfunction

    // input synchronisers
    logic sclMeta_r, sclS_r, sclD_r, sdaMeta_r, sdaS_r, sdaD_r;
    logic [1:0] selMeta_r, sel_r;
    always_ff @(posedge mclk) begin
        if (reset) begin
            {sclMeta_r, sclS_r, sclD_r} <= 3'h7;
            {sdaMeta_r, sdaS_r, sdaD_r} <= 3'h7;
            {selMeta_r, sel_r} <= 4'h0;
        end else begin
            {sclMeta_r, sclS_r, sclD_r} <= {pinIn.scl, sclMeta_r, sclS_r};
            {sdaMeta_r, sdaS_r, sdaD_r} <= {pinIn.sda, sdaMeta_r, sdaS_r};
            {selMeta_r, sel_r} <= {addrSelectHiPin, addrSelectLoPin, selMeta_r};
        end
    end

    logic sclRise, sclFall, startDet, stopDet;
    assign sclRise  = sclS_r & ~sclD_r;
    assign sclFall  = ~sclS_r & sclD_r;
    assign startDet = sclS_r & sclD_r & sdaD_r & ~sdaS_r;
    assign stopDet  = sclS_r & sclD_r & ~sdaD_r & sdaS_r;

    // state
    smaState_e   state_r, state_nxt;
    logic [3:0]  bitCnt_r, bitCnt_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic [5:0]  byteIdx_r, byteIdx_nxt;
    logic [5:0]  txIdx_r, txIdx_nxt;
    logic [7:0]  cmd_r, cmd_nxt;
    logic [15:0] ptr_r, ptr_nxt;
    logic [7:0]  count_r, count_nxt;
    logic [12:0] progCnt_r, progCnt_nxt;
    logic [19:0] eraseCnt_r, eraseCnt_nxt;
    logic [4:0]  erasePage_r, erasePage_nxt;
    logic        rw_r, rw_nxt;
    logic        ack_r, ack_nxt;
    logic        mastAck_r, mastAck_nxt;
    logic        blkRdArm_r, blkRdArm_nxt;
    logic        inTrans_r, inTrans_nxt;
    logic        eraseEn_r, eraseEn_nxt;
    logic        sdaOe_r, sdaOe_nxt;

    // memories and check byte
    logic              ramWr, eeProg, eeErase, crcClr, crcEn, txLoad;
    logic [RAM_AW-1:0] ramWrAddr;
    logic [EE_AW-1:0]  eeWrAddr;
    logic [7:0]        ramWrData, eeWrData, ramRd, eeRd, crcVal, crcByte, txByte;
    logic [7:0]        rxByte, memRd;
    logic [6:0]        myAddr;
    logic              byteDone, ptrIsEe, ptrIsRam, progBusy;

    assign myAddr   = {SLV_ADDR_HI, sel_r};
    assign rxByte   = {shift_r[6:0], sdaS_r};
    assign byteDone = (state_r == ST_RX) && sclRise && (bitCnt_r == 4'h7);
    assign ptrIsEe  = ptr_r[15:11] == EE_PREFIX;
    assign ptrIsRam = (ptr_r[15:8] == RAM_PTR_HI) && isRamCmd(ptr_r[7:0]);
    assign memRd    = ptrIsEe ? eeRd : ramRd;
    assign progBusy = progCnt_r != 13'h0000;
    assign eeErase  = (eraseCnt_r != 20'h00000) && (eraseCnt_r <= PAGE_BYTES);
    assign eeWrAddr = eeErase ? {erasePage_r, 5'(eraseCnt_r[4:0] - 5'h01)} : ptr_r[EE_AW-1:0];
    assign eeWrData = eeErase ? ERASED_BYTE : (rxByte & eeRd);

    // next byte to shift out
    always_comb begin
        if (!blkRdArm_r) begin
            txByte = memRd;
        end else if (txIdx_r == TX_COUNT_IDX) begin
            txByte = BLK_LEN;
        end else if (txIdx_r < TX_PEC_IDX) begin
            txByte = memRd;
        end else if (txIdx_r == TX_PEC_IDX) begin
            txByte = crcVal;
        end else begin
            txByte = IDLE_BYTE;
        end
    end

    always_comb begin
        state_nxt = state_r;      bitCnt_nxt = bitCnt_r;     shift_nxt = shift_r;
        byteIdx_nxt = byteIdx_r;  txIdx_nxt = txIdx_r;       cmd_nxt = cmd_r;
        ptr_nxt = ptr_r;          count_nxt = count_r;       rw_nxt = rw_r;
        ack_nxt = ack_r;          mastAck_nxt = mastAck_r;   blkRdArm_nxt = blkRdArm_r;
        inTrans_nxt = inTrans_r;  eraseEn_nxt = eraseEn_r;   sdaOe_nxt = sdaOe_r;
        erasePage_nxt = erasePage_r;
        progCnt_nxt  = progBusy ? progCnt_r - 13'h0001 : progCnt_r;
        eraseCnt_nxt = (eraseCnt_r != 20'h00000) ? eraseCnt_r - 20'h00001 : eraseCnt_r;
        ramWr = 1'b0;  ramWrAddr = cmd_r;  ramWrData = rxByte;  eeProg = 1'b0;
        crcClr = 1'b0; crcEn = 1'b0;       crcByte = rxByte;    txLoad = 1'b0;

        if (startDet) begin
            crcClr      = ~inTrans_r;
            inTrans_nxt = 1'b1;
            state_nxt   = ST_RX;
            bitCnt_nxt  = 4'h0;
            byteIdx_nxt = 6'h00;
            sdaOe_nxt   = 1'b0;
        end else if (stopDet) begin
            inTrans_nxt  = 1'b0;
            blkRdArm_nxt = 1'b0;
            state_nxt    = ST_IDLE;
            sdaOe_nxt    = 1'b0;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (sclRise) begin
                        shift_nxt  = rxByte;
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                    if (byteDone) begin
                        crcEn   = 1'b1;
                        ack_nxt = 1'b1;
                        if (byteIdx_r == 6'h00) begin
                            ack_nxt = (rxByte[7:1] == myAddr)
                                      && (eraseCnt_r == 20'h00000);
                            rw_nxt    = rxByte[0];
                            txIdx_nxt = TX_COUNT_IDX;
                        end else if (byteIdx_r == 6'h01) begin
                            cmd_nxt = rxByte;
                            if (isRamCmd(rxByte)) begin
                                ptr_nxt = {RAM_PTR_HI, rxByte};
                            end
                            if (rxByte == CMD_ERASE && eraseEn_r) begin
                                eraseCnt_nxt  = 20'(ERASE_N);
                                erasePage_nxt = ptr_r[EE_AW-1:5];
                            end
                            if (rxByte == CMD_BLK_RD) begin
                                blkRdArm_nxt = 1'b1;
                            end
                        end else if (isRamCmd(cmd_r)) begin
                            if (byteIdx_r == 6'h02) begin
                                ramWr = 1'b1;
                                if (cmd_r == CFG_ADDR) begin
                                    eraseEn_nxt = rxByte[CFG_ERASE_BIT];
                                end
                            end
                        end else if (isEeCmd(cmd_r)) begin
                            if (byteIdx_r == 6'h02) begin
                                ptr_nxt = {cmd_r, rxByte};
                            end else if (byteIdx_r == 6'h03) begin
                                eeProg      = 1'b1;
                                progCnt_nxt = 13'(PROG_N);
                            end
                        end else if (cmd_r == CMD_BLK_WR) begin
                            if (byteIdx_r == 6'h02) begin
                                count_nxt = rxByte;
                            end else if (count_r != 8'h00) begin
                                count_nxt = count_r - 8'h01;
                                ptr_nxt   = ptr_r + 16'h0001;
                                ramWrAddr = ptr_r[RAM_AW-1:0];
                                ramWr     = ptrIsRam;
                                eeProg    = ptrIsEe;
                                if (ptrIsEe) begin
                                    progCnt_nxt = 13'(PROG_N);
                                end
                            end
                        end
                    end
                    if (sclFall && bitCnt_r == 4'h8) begin
                        sdaOe_nxt = ack_r;
                        state_nxt = ack_r ? ST_ACK : ST_WAIT;
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        bitCnt_nxt  = 4'h0;
                        byteIdx_nxt = (byteIdx_r == 6'h3f) ? byteIdx_r : byteIdx_r + 6'h01;
                        if (rw_r) begin
                            txLoad = 1'b1;
                        end else begin
                            sdaOe_nxt = 1'b0;
                            state_nxt = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        bitCnt_nxt = bitCnt_r + 4'h1;
                        if (bitCnt_r == 4'h7) begin
                            sdaOe_nxt = 1'b0;
                            state_nxt = ST_RACK;
                        end else begin
                            sdaOe_nxt = ~shift_r[7];
                            shift_nxt = {shift_r[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        mastAck_nxt = ~sdaS_r;
                    end
                    if (sclFall) begin
                        txLoad    = mastAck_r;
                        state_nxt = mastAck_r ? ST_TX : ST_WAIT;
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sdaOe_nxt = 1'b0;
                end
                default: begin
                    state_nxt = ST_IDLE;
                    sdaOe_nxt = 1'b0;
                end
            endcase
            if (txLoad) begin
                state_nxt  = ST_TX;
                bitCnt_nxt = 4'h0;
                sdaOe_nxt  = ~txByte[7];
                shift_nxt  = {txByte[6:0], 1'b0};
                txIdx_nxt  = (txIdx_r == 6'h3f) ? txIdx_r : txIdx_r + 6'h01;
                crcEn      = 1'b1;
                crcByte    = txByte;
                if (blkRdArm_r && txIdx_r != TX_COUNT_IDX && txIdx_r < TX_PEC_IDX) begin
                    ptr_nxt = ptr_r + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= ST_IDLE;   bitCnt_r <= 4'h0;    shift_r <= 8'h00;
            byteIdx_r <= 6'h00;   txIdx_r <= 6'h00;    cmd_r <= 8'h00;
            ptr_r <= 16'h0000;    count_r <= 8'h00;    progCnt_r <= 13'h0000;
            eraseCnt_r <= 20'h00000;  erasePage_r <= 5'h00;
            rw_r <= 1'b0;         ack_r <= 1'b0;       mastAck_r <= 1'b0;
            blkRdArm_r <= 1'b0;   inTrans_r <= 1'b0;   eraseEn_r <= 1'b0;
            sdaOe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;     bitCnt_r <= bitCnt_nxt;   shift_r <= shift_nxt;
            byteIdx_r <= byteIdx_nxt; txIdx_r <= txIdx_nxt;     cmd_r <= cmd_nxt;
            ptr_r <= ptr_nxt;         count_r <= count_nxt;     progCnt_r <= progCnt_nxt;
            eraseCnt_r <= eraseCnt_nxt;   erasePage_r <= erasePage_nxt;
            rw_r <= rw_nxt;           ack_r <= ack_nxt;         mastAck_r <= mastAck_nxt;
            blkRdArm_r <= blkRdArm_nxt;   inTrans_r <= inTrans_nxt;
            eraseEn_r <= eraseEn_nxt; sdaOe_r <= sdaOe_nxt;
        end
    end

    sma_mem #(.AW(RAM_AW)) uRam (
        .mclk   (mclk),
        .wrEn   (ramWr),
        .wrAddr (ramWrAddr),
        .wrData (ramWrData),
        .rdAddr (ptr_r[RAM_AW-1:0]),
        .rdData (ramRd)
    );

    sma_mem #(.AW(EE_AW)) uEe (
        .mclk   (mclk),
        .wrEn   (eeProg | eeErase),
        .wrAddr (eeWrAddr),
        .wrData (eeWrData),
        .rdAddr (ptr_r[EE_AW-1:0]),
        .rdData (eeRd)
    );

    sma_crc8 uCrc (
        .mclk  (mclk),
        .reset (reset),
        .clr   (crcClr),
        .en    (crcEn),
        .data  (crcByte),
        .crc   (crcVal)
    );

    // open-drain pins; scl stretched while a byte programs
    assign pinOut.sclOut = 1'b0;
    assign pinOut.sdaOut = 1'b0;
    assign pinOut.sdaOe  = sdaOe_r;
    assign pinOut.sclOe  = progBusy && inTrans_r && !sclS_r
                           && (state_r == ST_ACK || state_r == ST_RX);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence ackEnter;
        state_r != ST_ACK ##1 state_r == ST_ACK;
    endsequence

    a_addr_match: assert property ((state_r == ST_ACK && byteIdx_r == 6'h00) |->
        shift_r[7:1] == myAddr) else $error("ack given to foreign address");
    a_erase_nack: assert property ((state_r == ST_ACK && byteIdx_r == 6'h00) |->
        eraseCnt_r == 20'h00000) else $error("address acked during erase");
    a_ack_drive: assert property (ackEnter |-> sdaOe_r)
        else $error("ack not driven");
    a_ram_write: assert property ((ramWr && cmd_r != CMD_BLK_WR) |->
        (ramWrAddr == cmd_r && isRamCmd(cmd_r))) else $error("ram write misdirected");
    a_ptr_load: assert property ((byteDone && byteIdx_r == 6'h02 && isEeCmd(cmd_r)) |=>
        ptr_r == {$past(cmd_r), $past(rxByte)}) else $error("eeprom pointer not loaded");
    a_prog_busy: assert property ((eeProg && !eeErase) |=>
        progCnt_r == 13'(PROG_N)) else $error("programming time not started");
    a_scl_stretch: assert property ((progBusy && inTrans_r && state_r == ST_ACK
        && !sclS_r) |-> pinOut.sclOe) else $error("scl not stretched");
    a_erase_page: assert property (eeErase |-> eeWrAddr[EE_AW-1:5] == erasePage_r)
        else $error("erase outside page");
    a_blk_count: assert property ((txLoad && blkRdArm_r && txIdx_r == TX_COUNT_IDX) |->
        ##1 (shift_r == {BLK_LEN[6:0], 1'b0})) else $error("block count wrong");
    a_pec_byte: assert property ((txLoad && blkRdArm_r && txIdx_r == TX_PEC_IDX) |->
        txByte == crcVal) else $error("check byte not crc");
    a_ptr_step: assert property ((txLoad && blkRdArm_r && txIdx_r != TX_COUNT_IDX
        && txIdx_r < TX_PEC_IDX) |=> ptr_r == $past(ptr_r) + 16'h0001)
        else $error("pointer not advanced");
endmodule

// >>> core/sma_pkg.sv
package sma_pkg;

    // slave address and command space
    localparam logic [4:0] SLV_ADDR_HI   = 5'h11;
    localparam logic [7:0] RAM_TOP       = 8'hdf;
    localparam logic [7:0] CMD_EE_LO     = 8'hf8;
    localparam logic [7:0] CMD_EE_HI     = 8'hfb;
    localparam logic [7:0] CMD_BLK_WR    = 8'hfc;
    localparam logic [7:0] CMD_BLK_RD    = 8'hfd;
    localparam logic [7:0] CMD_ERASE     = 8'hfe;
    localparam logic [4:0] EE_PREFIX     = 5'h1f;
    localparam logic [7:0] RAM_PTR_HI    = 8'h00;
    localparam logic [7:0] CFG_ADDR      = 8'h90;
    localparam int         CFG_ERASE_BIT = 2;

    // block read framing
    localparam logic [7:0] BLK_LEN       = 8'h20;
    localparam logic [5:0] TX_COUNT_IDX  = 6'h00;
    localparam logic [5:0] TX_PEC_IDX    = 6'h21;
    localparam logic [7:0] IDLE_BYTE     = 8'hff;

    // memory shape
    localparam int         RAM_AW        = 8;
    localparam int         EE_AW         = 10;
    localparam logic [7:0] ERASED_BYTE   = 8'hff;
    localparam logic [19:0] PAGE_BYTES   = 20'h00020;

    // crc-8, x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_POLY      = 8'h07;
    localparam logic [7:0] CRC_INIT      = 8'h00;

    // timing
    localparam int CLK_HZ        = 25000000;
    localparam int PROG_TIME_US  = 250;
    localparam int ERASE_TIME_MS = 20;
    localparam int PROG_CYCLES   = (CLK_HZ / 1000000) * PROG_TIME_US;
    localparam int ERASE_CYCLES  = (CLK_HZ / 1000) * ERASE_TIME_MS;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX   = 6'h02,
        ST_ACK  = 6'h04,
        ST_TX   = 6'h08,
        ST_RACK = 6'h10,
        ST_WAIT = 6'h20
    } smaState_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } smaPinIn_s;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } smaPinOut_s;

endpackage

// >>> core/sma_mem.sv
`timescale 1ns/1ps
module sma_mem
    import sma_pkg::*;
#(
    parameter int AW = 8
) (
    // clock
    input  wire logic          mclk,
    // write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [7:0]    wrData,
    // read port
    input  wire logic [AW-1:0] rdAddr,
    output logic      [7:0]    rdData
);
    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// >>> core/sma_crc8.sv
`timescale 1ns/1ps
module sma_crc8
    import sma_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // control
    input  wire logic       clr,
    input  wire logic       en,
    input  wire logic [7:0] data,
    // result
    output logic      [7:0] crc
);
    logic [7:0] crc_r;
    logic [7:0] crc_nxt;

    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] v;
        v = c ^ d;
        for (int i = 0; i < 8; i++) begin
            v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
        end
        return v;
    endfunction

    always_comb begin
        crc_nxt = crc_r;
        if (clr) begin
            crc_nxt = CRC_INIT;
        end else if (en) begin
            crc_nxt = crcStep(crc_r, data);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            crc_r <= CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    assign crc = crc_r;
endmodule

// >>> sim/sma_master_model.sv
`timescale 1ns/1ps
module sma_master_model
    import sma_pkg::*;
(
    // device pull-downs
    input  wire logic sclOe,
    input  wire logic sdaOe,
    // wire levels
    output smaPinIn_s pinIn
);
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;
    // open drain, released lines float high
    assign pinIn.scl = sclDrv & !sclOe;
    assign pinIn.sda = sdaDrv & !sdaOe;
    // release scl and wait out stretching
    task automatic rel();
        sclDrv = 1'b1;
        for (int i = 0; i < 4000 && !pinIn.scl; i++) #40;
    endtask
    task automatic bitx(input logic bo, output logic bi);
        sdaDrv = bo;
        #160 rel();
        #80 bi = pinIn.sda;
        #80 sclDrv = 1'b0;
    endtask
    // also serves as repeated start
    task automatic start();
        sdaDrv = 1'b1;
        #160 rel();
        #160 sdaDrv = 1'b0;
        #160 sclDrv = 1'b0;
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        #160 rel();
        #160 sdaDrv = 1'b1;
        #160;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bitx(d[i], b);
        bitx(1'b1, b);
        ack = !b;
    endtask
    // ackIt low gives the closing nack
    task automatic rd(input logic ackIt, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(!ackIt, b);
    endtask
endmodule

// >>> sim/smbus_memory_access_slave_bench.sv
`timescale 1ns/1ps
module smbus_memory_access_slave_bench
    import sma_pkg::*;
;
    typedef struct {
        logic [7:0] cmd;
        logic [7:0] val;
    } smaRow_s;
    localparam logic [6:0] DEV = {SLV_ADDR_HI, 2'b10};
    logic       mclk            = 1'b0;
    logic       reset           = 1'b1;
    logic       addrSelectHiPin = 1'b1;
    logic       addrSelectLoPin = 1'b0;
    int         stretchCycles   = 0;
    int         stretchMark     = 0;
    logic       ack;
    logic [7:0] d;
    logic [7:0] crc;
    int         numErrors       = 0;
    int         comparisons     = 0;
    int         cycles          = 0;
    smaPinIn_s  pinIn;
    smaPinOut_s pinOut;
    smaRow_s    rows[3] = '{'{8'h00, 8'h5a}, '{8'hdf, 8'ha5}, '{8'h40, 8'h3c}};

    sma_core #(.PROG_N(20), .ERASE_N(200)) dut (
        .mclk            (mclk),
        .reset           (reset),
        .addrSelectHiPin (addrSelectHiPin),
        .addrSelectLoPin (addrSelectLoPin),
        .pinIn           (pinIn),
        .pinOut          (pinOut)
    );
    sma_master_model m (
        .sclOe (pinOut.sclOe),
        .sdaOe (pinOut.sdaOe),
        .pinIn (pinIn)
    );

    initial forever #20 mclk = !mclk;

    task automatic conclude();
        $display("errors %0d comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (pinOut.sclOe === 1'b1) stretchCycles <= stretchCycles + 1;
        if (cycles == 30000) begin
            numErrors = numErrors + 1;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] x;
        x = c ^ b;
        for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction
    // one byte out, folded into the running check byte
    task automatic wb(input logic [7:0] b, input logic expAck = 1'b1);
        m.wr(b, ack);
        crc = crcStep(crc, b);
        check({7'h00, ack}, {7'h00, expAck});
    endtask
    task automatic rb(input logic ackIt, input logic [7:0] exp);
        m.rd(ackIt, d);
        crc = crcStep(crc, exp);
        check(d, exp);
    endtask
    task automatic go(input logic rw);
        m.start();
        wb({DEV, rw});
    endtask
    task automatic fin();
        m.stop();
        repeat (4) @(negedge mclk);
    endtask
    task automatic ram(input logic [7:0] a);
        go(1'b0);
        wb(a);
        fin();
    endtask
    task automatic ee(input logic [7:0] lo);
        go(1'b0);
        wb(8'hf8);
        wb(lo);
        fin();
    endtask
    task automatic rdAt(input logic [7:0] exp);
        go(1'b1);
        rb(1'b0, exp);
        fin();
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        foreach (rows[i]) begin
            crc = 8'h00;
            go(1'b0);
            wb(rows[i].cmd);
            wb(rows[i].val);
            wb(crc);
            fin();
            ram(rows[i].cmd);
            rdAt(rows[i].val);
        end
        // foreign and stale addresses
        m.start();
        wb(8'ha0, 1'b0);
        fin();
        m.start();
        wb({SLV_ADDR_HI, 2'b00, 1'b0}, 1'b0);
        fin();
        // erase page 0 with low pointer bits set
        go(1'b0);
        wb(8'h90);
        wb(8'h04);
        fin();
        ee(8'h05);
        go(1'b0);
        wb(8'hfe);
        fin();
        m.start();
        wb({DEV, 1'b0}, 1'b0);
        fin();
        repeat (200) @(negedge mclk);
        ee(8'h1f);
        rdAt(8'hff);
        // single byte program, clock held low
        stretchMark = stretchCycles;
        crc = 8'h00;
        ee(8'h03);
        go(1'b0);
        wb(8'hf8);
        wb(8'h03);
        wb(8'h96);
        wb(crc);
        fin();
        check({7'h00, stretchCycles > stretchMark}, 8'h01);
        ee(8'h03);
        rdAt(8'h96);
        // block writes, first inside the erased page, then to ram
        ee(8'h08);
        go(1'b0);
        wb(8'hfc);
        wb(8'h02);
        wb(8'h12);
        wb(8'h34);
        fin();
        ram(8'h20);
        go(1'b0);
        wb(8'hfc);
        wb(8'h02);
        wb(8'h11);
        wb(8'h22);
        fin();
        ram(8'h21);
        rdAt(8'h22);
        // block read of page 0 with check byte
        ee(8'h00);
        crc = 8'h00;
        go(1'b0);
        wb(8'hfd);
        go(1'b1);
        rb(1'b1, 8'h20);
        for (int i = 0; i < 32; i++)
            rb(1'b1, i == 3 ? 8'h96 : i == 8 ? 8'h12 : i == 9 ? 8'h34 : 8'hff);
        m.rd(1'b0, d);
        check(d, crc);
        fin();
        // mid-run reset clears pointer, erase enable and pin drive
        reset = 1'b1;
        repeat (8) @(negedge mclk);
        check({6'h00, pinOut.sclOe, pinOut.sdaOe}, 8'h00);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        go(1'b0);
        wb(8'hfe);
        fin();
        rdAt(8'h5a);
        check({6'h00, pinOut.sclOut, pinOut.sdaOut}, 8'h00);
        conclude();
    end
endmodule
